// ---- hw/ext_bus_pkg.sv ----
// Purpose: Constants shared by the external bus chip select port.
// Assumes: 200 MHz system clock.
// Notes: Pin widths, state encodings and timing counts.
package ext_bus_pkg;
   localparam int ADDR_W = 26;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int SELECTS = 6;
   localparam int BOOT_W = 4;
   localparam int SEL_ACCESS_ACKNOWLEDGE_IN = 4;
   localparam int SEL_SD_LO = 2;
   localparam int SEL_SD_HI = 3;
   localparam int BOOT_MSB = 3;
   // Burst clock divider: half period in ns, converted to system cycles
   localparam int BCLK_HALF_NS = 10;
   localparam int CLK_NS = 5;
   localparam logic [3:0] BCLK_HALF_CYC = 4'(BCLK_HALF_NS / CLK_NS);
   // Address latch pulse width in cycles
   localparam logic [3:0] LATCH_CYC = 4'h2;
   // Strobe phase of a non-acknowledged access
   localparam logic [3:0] ACCESS_CYC = 4'h4;
   // Longest wait for acknowledge before giving up
   localparam logic [7:0] ACK_TIMEOUT = 8'hFF;
   localparam logic [BOOT_W-1:0] BOOT_RESET = 4'h0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LATCH = 3'b001,
      ST_STROBE = 3'b011,
      ST_DONE = 3'b010,
      ST_RESTART = 3'b110
   } bus_state_t;
endpackage : ext_bus_pkg

// ---- hw/sync_two_ff.sv ----
// Purpose: Two flip-flop synchroniser for pins from outside the domain.
// Assumes: Single system clock.
// Notes: Output is the second stage only.
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : sync_two_ff

// ---- hw/ext_bus_port.sv ----
// Purpose: External bus pin engine with chip selects, burst flash support
//    and boot mode capture.
// Assumes: Internal request is held until done; one clock domain.
// Notes: Wait states and SDRAM sequencing live elsewhere.
//
// What this block does
// - Drive 26-bit address and carry 32-bit two-way data bus.
// - Four low strobes; strobe 0 is bits 31:24 down to strobe 3 bits 7:0.
// - Low output enable lets memory drive data during reads.
// - Direction pin high for read, low for write.
// - Six low selects; selects 3,2 shared with SDRAM selects, SDRAM default.
// - Acknowledge input shares pin with select 4.
// - Burst end input aborts burst; restart with long first access.
// - Low address latch pulse captures burst start address.
// - Burst clock driven only during burst mode.
// - Sample four boot pins at system reset to set boot mode.
`timescale 1ns/1ps
module ext_bus_port
   import ext_bus_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Internal request side
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic req_burst,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [LANES-1:0] req_lanes,
   input wire logic [2:0] req_select,
   output logic req_done,
   output logic [DATA_W-1:0] rsp_rdata,
   // Configuration
   input wire logic function_mux_control,
   input wire logic ack_enable,
   input wire logic [1:0] sdram_req_n,
   output logic [BOOT_W-1:0] boot_mode,
   // External pins
   output logic [ADDR_W-1:0] addr_out,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_n,
   output logic byte_lane_strobe_0_n,
   output logic byte_lane_strobe_1_n,
   output logic byte_lane_strobe_2_n,
   output logic byte_lane_strobe_3_n,
   output logic output_enable_n,
   output logic read_write,
   output logic [SELECTS-1:0] chip_select_n,
   output logic [1:0] sdram_select_n,
   input wire logic access_acknowledge_in,
   input wire logic burst_end_request_n,
   output logic burst_address_latch_n,
   output logic burst_clock,
   input wire logic [BOOT_W-1:0] boot_pins
);

   bus_state_t state_reg, state_next;
   logic [3:0] cnt_reg;
   logic [7:0] wait_reg;
   logic [3:0] bdiv_reg;
   logic bclk_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [LANES-1:0] lanes_reg;
   logic [2:0] sel_reg;
   logic read_reg;
   logic burst_reg;
   logic boot_taken_reg;
   logic [BOOT_W-1:0] boot_reg;
   logic ack_s;
   logic burst_end_s;
   logic [BOOT_W-1:0] boot_s;

   sync_two_ff #(.W(1)) u_sync_ack (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(access_acknowledge_in),
      .sync_out(ack_s)
   );
   sync_two_ff #(.W(1)) u_sync_end (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(burst_end_request_n),
      .sync_out(burst_end_s)
   );
   // Runs free through reset, or the capture would see a cleared stage
   sync_two_ff #(.W(BOOT_W)) u_sync_boot (
      .sys_clk(sys_clk),
      .rst(1'b0),
      .async_in(boot_pins),
      .sync_out(boot_s)
   );

   // Strobe lane n maps to MSB-first byte; strobe 0 is the top byte
   function automatic logic lane_active(input logic [LANES-1:0] l,
                                        input int n);
      return l[LANES-1-n];
   endfunction : lane_active

   wire busy = (state_reg == ST_STROBE);
   wire active = (state_reg != ST_IDLE);
   wire burst_end = burst_reg && !burst_end_s;
   // Pin 4 turns into an input when acknowledge is selected
   wire ack_mode = ack_enable;
   wire cnt_zero = (cnt_reg == 4'h0);
   wire ack_ok = ack_mode ? (ack_s || wait_reg == ACK_TIMEOUT) : cnt_zero;
   wire bclk_tick = (bdiv_reg == BCLK_HALF_CYC - 4'h1);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (req_valid) state_next = req_burst ? ST_LATCH : ST_STROBE;
         ST_LATCH:
            if (cnt_zero) state_next = ST_STROBE;
         ST_STROBE: begin
            if (burst_end) state_next = ST_RESTART;
            else if (ack_ok) state_next = ST_DONE;
         end
         ST_DONE: state_next = ST_IDLE;
         ST_RESTART: state_next = ST_LATCH;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) state_reg <= ST_IDLE;
      else state_reg <= state_next;
   end

   // Long first access: restart reloads the latch count, then the full access count
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_reg <= 4'h0;
      end else if (state_reg == ST_IDLE && req_valid) begin
         cnt_reg <= req_burst ? LATCH_CYC - 4'h1 : ACCESS_CYC - 4'h1;
      end else if (state_reg == ST_LATCH && cnt_zero) begin
         cnt_reg <= ACCESS_CYC - 4'h1;
      end else if (state_reg == ST_RESTART) begin
         cnt_reg <= LATCH_CYC - 4'h1;
      end else if (!cnt_zero) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || !busy) wait_reg <= 8'h00;
      else if (wait_reg != ACK_TIMEOUT) wait_reg <= wait_reg + 8'h01;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_reg <= '0;
         wdata_reg <= '0;
         lanes_reg <= '0;
         sel_reg <= 3'h0;
         read_reg <= 1'b1;
         burst_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && req_valid) begin
         addr_reg <= req_addr;
         wdata_reg <= req_wdata;
         lanes_reg <= req_lanes;
         sel_reg <= req_select;
         read_reg <= req_read;
         burst_reg <= req_burst;
      end else if (state_reg == ST_DONE) begin
         read_reg <= 1'b1;
         burst_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) rdata_reg <= '0;
      else if (busy && read_reg && ack_ok) rdata_reg <= data_in;
   end

   // Burst clock from a divider, held low outside bursts
   always_ff @(posedge sys_clk) begin
      if (rst || !burst_reg) begin
         bdiv_reg <= 4'h0;
         bclk_reg <= 1'b0;
      end else if (bclk_tick) begin
         bdiv_reg <= 4'h0;
         bclk_reg <= !bclk_reg;
      end else begin
         bdiv_reg <= bdiv_reg + 4'h1;
      end
   end

   // Boot pins caught once after reset release, after synchronising
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         boot_taken_reg <= 1'b0;
         boot_reg <= BOOT_RESET;
      end else if (!boot_taken_reg) begin
         boot_taken_reg <= 1'b1;
         boot_reg <= boot_s;
      end
   end
   assign boot_mode = boot_reg;

   assign addr_out = addr_reg;
   assign data_out = wdata_reg;
   assign data_oe_n = !(active && !read_reg);
   assign output_enable_n = !(busy && read_reg);
   assign read_write = read_reg;
   assign byte_lane_strobe_0_n = !(busy && lane_active(lanes_reg, 0));
   assign byte_lane_strobe_1_n = !(busy && lane_active(lanes_reg, 1));
   assign byte_lane_strobe_2_n = !(busy && lane_active(lanes_reg, 2));
   assign byte_lane_strobe_3_n = !(busy && lane_active(lanes_reg, 3));
   assign burst_address_latch_n = !(state_reg == ST_LATCH);
   assign burst_clock = bclk_reg;
   assign req_done = (state_reg == ST_DONE);
   assign rsp_rdata = rdata_reg;

   // Selects: SDRAM selects own pins 2,3 when the mux bit is low
   genvar gi;
   generate
      for (gi = 0; gi < SELECTS; gi++) begin : g_cs
         wire hit = active && !(state_reg == ST_DONE) && (sel_reg == gi);
         if (gi == SEL_SD_LO || gi == SEL_SD_HI) begin : g_shared
            assign chip_select_n[gi] = function_mux_control ?
               !hit : sdram_req_n[gi-SEL_SD_LO];
         end else if (gi == SEL_ACCESS_ACKNOWLEDGE_IN) begin : g_ack
            // Pin released high while it serves as acknowledge input
            assign chip_select_n[gi] = ack_mode ? 1'b1 : !hit;
         end else begin : g_plain
            assign chip_select_n[gi] = !hit;
         end
      end
   endgenerate
   assign sdram_select_n = function_mux_control ? 2'b11 : sdram_req_n;

   // Assertions
   a_strobe_oe_read: assert property (@(posedge sys_clk)
      disable iff (rst)
      !output_enable_n |-> read_write && busy)
      else $error("Output enable outside read strobe");
   a_dir_write: assert property (@(posedge sys_clk)
      disable iff (rst)
      !data_oe_n |-> !read_write && output_enable_n)
      else $error("Data driven during read");
   a_idle_pins: assert property (@(posedge sys_clk)
      disable iff (rst)
      !active |-> read_write && data_oe_n && output_enable_n)
      else $error("Bus not parked in read direction when idle");
   a_lane_map: assert property (@(posedge sys_clk)
      disable iff (rst)
      busy |-> byte_lane_strobe_0_n == !lanes_reg[3]
            && byte_lane_strobe_3_n == !lanes_reg[0])
      else $error("Byte lane strobe mapping wrong");
   a_strobe_idle: assert property (@(posedge sys_clk)
      disable iff (rst)
      !busy |-> byte_lane_strobe_0_n && byte_lane_strobe_1_n
            && byte_lane_strobe_2_n && byte_lane_strobe_3_n)
      else $error("Byte lane strobe outside strobe phase");
   a_sdram_default: assert property (@(posedge sys_clk)
      disable iff (rst)
      !function_mux_control |-> chip_select_n[3:2] == sdram_req_n)
      else $error("SDRAM selects not on shared pins");
   a_ack_pin_free: assert property (@(posedge sys_clk)
      disable iff (rst)
      ack_mode |-> chip_select_n[SEL_ACCESS_ACKNOWLEDGE_IN])
      else $error("Select 4 driven in acknowledge mode");
   sequence s_abort;
      busy && burst_end;
   endsequence
   a_burst_restart: assert property (@(posedge sys_clk)
      disable iff (rst)
      s_abort |=> state_reg == ST_RESTART ##1 !burst_address_latch_n [*2])
      else $error("Burst end did not restart with latch");
   sequence s_latch_start;
      $fell(burst_address_latch_n);
   endsequence
   a_latch_pair: assert property (@(posedge sys_clk)
      disable iff (rst)
      s_latch_start |=> !burst_address_latch_n ##1 burst_address_latch_n)
      else $error("Address latch pulse not two cycles");
   a_bclk_idle: assert property (@(posedge sys_clk)
      disable iff (rst)
      !burst_reg |=> !burst_clock)
      else $error("Burst clock toggles outside burst");
   sequence s_plain_start;
      state_reg == ST_IDLE && req_valid && !req_burst && !ack_mode;
   endsequence
   a_plain_length: assert property (@(posedge sys_clk)
      disable iff (rst)
      s_plain_start |=> busy [*4] ##1 req_done)
      else $error("Plain access not four strobe cycles");
   a_ack_wait: assert property (@(posedge sys_clk)
      disable iff (rst)
      busy && ack_mode && !ack_s && wait_reg != ACK_TIMEOUT && !burst_end
      |=> !req_done)
      else $error("Access finished without acknowledge");
   a_done_pulse: assert property (@(posedge sys_clk)
      disable iff (rst)
      req_done |=> !req_done)
      else $error("Done held longer than one cycle");
   a_boot_hold: assert property (@(posedge sys_clk)
      disable iff (rst)
      boot_taken_reg |=> $stable(boot_mode))
      else $error("Boot mode changed after capture");
endmodule : ext_bus_port

// ---- bench/ext_mem_model.sv ----
// Purpose: Memory and burst flash model at the far side of the bus.
// Assumes: Pins are sampled on the system clock.
// Notes: A released data bus shows the inverse of its last value.
`timescale 1ns/1ps
module ext_mem_model (
   // Clock
   input wire logic sys_clk,
   // Bus pins
   input wire logic [25:0] addr_out,
   input wire logic [31:0] data_out,
   input wire logic data_oe_n,
   input wire logic output_enable_n,
   input wire logic read_write,
   input wire logic [5:0] chip_select_n,
   output logic [31:0] data_in,
   output logic access_acknowledge_in,
   output logic burst_end_request_n,
   // Scenario control
   input wire logic [7:0] ack_wait,
   input wire logic end_cmd
);
   logic [31:0] mem [16];
   logic [31:0] last_reg = 32'h0000_0000;
   logic [7:0] wait_reg = 8'h00;
   wire logic any_sel = ~&chip_select_n;
   wire logic drive = any_sel & ~output_enable_n & read_write;
   // Changing pattern so a stale bus never matches by luck
   assign data_in = drive ? mem[addr_out[3:0]] : ~last_reg;
   assign access_acknowledge_in = any_sel & (wait_reg >= ack_wait);
   always_ff @(posedge sys_clk) begin
      burst_end_request_n <= ~end_cmd;
      last_reg <= data_in;
      wait_reg <= any_sel ? wait_reg + 8'h01 : 8'h00;
      if (any_sel & ~read_write & ~data_oe_n) begin
         mem[addr_out[3:0]] <= data_out;
      end
   end
endmodule : ext_mem_model

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the external bus port.
// Assumes: Request held until done; pins driven on the rising edge.
// Notes: Bursts are ended from the model while in the strobe phase.
`timescale 1ns/1ps
module tb;
   import ext_bus_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0, req_read = 1'b0, req_burst = 1'b0;
   logic [ADDR_W-1:0] req_addr = 26'h000_0000;
   logic [DATA_W-1:0] req_wdata = 32'h0000_0000;
   logic [LANES-1:0] req_lanes = 4'hF;
   logic [2:0] req_select = 3'h0;
   logic function_mux_control = 1'b0, ack_enable = 1'b0, end_cmd = 1'b0;
   logic [1:0] sdram_req_n = 2'h3;
   logic [BOOT_W-1:0] boot_pins = 4'h5; // Top pin held low, stable
   logic [7:0] ack_wait = 8'hFF;
   logic req_done, data_oe_n, output_enable_n, read_write, burst_clock;
   logic byte_lane_strobe_0_n, byte_lane_strobe_1_n, byte_lane_strobe_2_n;
   logic byte_lane_strobe_3_n, access_acknowledge_in, burst_end_request_n;
   logic burst_address_latch_n;
   logic [DATA_W-1:0] rsp_rdata, data_in, data_out;
   logic [BOOT_W-1:0] boot_mode;
   logic [ADDR_W-1:0] addr_out, c_a;
   logic [SELECTS-1:0] chip_select_n, c_cs;
   logic [1:0] sdram_select_n;
   logic [3:0] c_stb;
   logic c_oe, c_rw, seen, bclk_prev;
   int n, lat, bct, err_count = 0, comparisons = 0;
   wire logic [3:0] stb = {byte_lane_strobe_0_n, byte_lane_strobe_1_n,
      byte_lane_strobe_2_n, byte_lane_strobe_3_n};
   always #2.5 sys_clk = ~sys_clk;
   ext_bus_port ext_bus_port_i (.sys_clk, .rst, .req_valid, .req_read,
      .req_burst, .req_addr, .req_wdata, .req_lanes, .req_select, .req_done,
      .rsp_rdata, .function_mux_control, .ack_enable, .sdram_req_n,
      .boot_mode, .addr_out, .data_in, .data_out, .data_oe_n,
      .byte_lane_strobe_0_n, .byte_lane_strobe_1_n, .byte_lane_strobe_2_n,
      .byte_lane_strobe_3_n, .output_enable_n, .read_write, .chip_select_n,
      .sdram_select_n, .access_acknowledge_in, .burst_end_request_n,
      .burst_address_latch_n, .burst_clock, .boot_pins);
   ext_mem_model ext_mem_model_i (.sys_clk, .addr_out, .data_out,
      .data_oe_n, .output_enable_n, .read_write, .chip_select_n, .data_in,
      .access_acknowledge_in, .burst_end_request_n, .ack_wait, .end_cmd);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // One access; records pins at the first strobe cycle
   task automatic access(input logic rd, input logic bu,
      input logic [2:0] sel, input logic [3:0] ln, input logic [31:0] wd);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_read <= rd;
      req_burst <= bu;
      req_select <= sel;
      req_lanes <= ln;
      req_wdata <= wd;
      req_addr <= 26'h000_0005 + 26'(sel);
      n = 0;
      lat = 0;
      bct = 0;
      seen = 1'b0;
      bclk_prev = burst_clock;
      while (req_done !== 1'b1 && n < 400) begin
         @(negedge sys_clk);
         n++;
         lat += int'(burst_address_latch_n === 1'b0);
         bct += int'(burst_clock !== bclk_prev);
         bclk_prev = burst_clock;
         if (!seen && stb !== 4'hF) begin
            seen = 1'b1;
            c_stb = stb;
            c_cs = chip_select_n;
            c_oe = output_enable_n;
            c_rw = read_write;
            c_a = addr_out;
         end
      end
      chk(32'(n < 400), 32'h1);
      @(posedge sys_clk);
      req_valid <= 1'b0;
   endtask : access
   task automatic write_read();
      access(1'b0, 1'b0, 3'h0, 4'hF, 32'hA5C3_0F96);
      chk(32'(c_rw), 32'h0);
      chk(32'(c_oe), 32'h1);
      chk(32'(c_a), 32'h000_0005);
      access(1'b1, 1'b0, 3'h0, 4'b1010, 32'h0000_0000);
      chk(rsp_rdata, 32'hA5C3_0F96);
      chk(32'(c_stb), 32'h5);
      chk(32'(c_rw), 32'h1);
      chk(32'(c_oe), 32'h0);
      chk(32'(n <= 8), 32'h1);
   endtask : write_read
   task automatic select_sweep();
      @(posedge sys_clk);
      function_mux_control <= 1'b1;
      for (int s = 0; s < 6; s++) begin
         access(1'b0, 1'b0, 3'(s), 4'hF, 32'h1234_5678);
         chk(32'(c_cs), {26'h000_0000, ~(6'h01 << s)});
      end
      chk(32'(sdram_select_n), 32'h3);
      @(posedge sys_clk);
      function_mux_control <= 1'b0;
      sdram_req_n <= 2'b01;
      @(negedge sys_clk);
      chk(32'(sdram_select_n), 32'h1);
      // A low SDRAM select would look like a live access to the model
      @(posedge sys_clk);
      sdram_req_n <= 2'b11;
   endtask : select_sweep
   task automatic ack_wait_test();
      @(posedge sys_clk);
      ack_enable <= 1'b1;
      ack_wait <= 8'h1E;
      access(1'b0, 1'b0, 3'h1, 4'hF, 32'h0F0F_0F0F);
      chk(32'(n >= 30 && n <= 40), 32'h1);
      chk(32'(c_cs[SEL_ACCESS_ACKNOWLEDGE_IN]), 32'h1);
      // No acknowledge in time: the timeout ends the access
      ack_wait <= 8'hFF;
      access(1'b0, 1'b0, 3'h5, 4'hF, 32'hF0F0_F0F0);
      chk(32'(n >= 255 && n <= 262), 32'h1);
      @(posedge sys_clk);
      ack_enable <= 1'b0;
   endtask : ack_wait_test
   task automatic burst_test();
      access(1'b1, 1'b1, 3'h0, 4'hF, 32'h0000_0000);
      chk(32'(lat), 32'h2);
      chk(32'(bct > 0), 32'h1);
      // Clock stops one cycle after the burst flag drops
      repeat (2) @(negedge sys_clk);
      chk(32'(burst_clock), 32'h0);
      fork
         access(1'b1, 1'b1, 3'h0, 4'hF, 32'h0000_0000);
         begin
            repeat (3) @(posedge sys_clk);
            end_cmd <= 1'b1;
            repeat (2) @(posedge sys_clk);
            end_cmd <= 1'b0;
         end
      join
      chk(32'(lat), 32'h4);
   endtask : burst_test
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      chk(32'(chip_select_n), 32'h3F);
      chk(32'(burst_clock), 32'h0);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(32'(boot_mode), 32'h5);
      write_read();
      select_sweep();
      ack_wait_test();
      burst_test();
      report_and_stop();
   end
endmodule : tb
